/* hw/fbr_defines.svh */
`ifndef FBR_DEFINES_SVH
`define FBR_DEFINES_SVH
// Functional notes
// - Carry traffic both ways at any rate from 9600 bit/s to 12 Mbit/s.
// - Regenerate every forwarded bit from own timing at the detected rate.
// - Lock the rate on the first good frame from either side.
// - Release lock after threshold consecutive faulty frames or idle timeout.
// - Default settings release after 31 faulty frames or 5 s idle.
// - Without extended retry the threshold is selectable from 1 to 8.
// - With extended retry the threshold is 31, 63, 127 or 255.
// - Rate lock indicator lit while locked, dark when no rate identified.
// - Channel one indicator steady on link, blinks on light only, else off.
// - Electrical receive indicator blinks while electrical data is forwarded.
// - Optical receive indicator blinks while optical data is forwarded.
// - Local fail indicator steady on while own fibre link is down.
// - Remote fail indicator steady on while a far link is down.
// - Both fail indicators blink on hardware error or invalid switches.
// - All indicators on for about one second after power-up.
// - A switch limits the status output to local link failure only.
// - Check start delimiter of each frame; a bad one is a faulty frame.
// - Two switches select the idle timeout, default 5 s.
// - Status output normal while links up, fault on link or power loss.
// - With one fibre broken the unit still lit blinks channel one.
`define FBR_CLK_HZ 50000000
`define FBR_NUM_RATES 10
`define FBR_RATE0_BPS 9600
`define FBR_RATE1_BPS 19200
`define FBR_RATE2_BPS 45450
`define FBR_RATE3_BPS 93750
`define FBR_RATE4_BPS 187500
`define FBR_RATE5_BPS 500000
`define FBR_RATE6_BPS 1500000
`define FBR_RATE7_BPS 3000000
`define FBR_RATE8_BPS 6000000
`define FBR_RATE9_BPS 12000000
`define FBR_RATE_RST 4'h0
`define FBR_SD1 8'h10
`define FBR_SD2 8'h68
`define FBR_SD3 8'hA2
`define FBR_SD4 8'hDC
`define FBR_CHAR_BITS 4'hB
`define FBR_GAP_BITS 4'hB
`define FBR_EXT_THR0 8'h1F
`define FBR_EXT_THR1 8'h3F
`define FBR_EXT_THR2 8'h7F
`define FBR_EXT_THR3 8'hFF
`define FBR_TMO0_S 5
`define FBR_TMO1_S 1
`define FBR_TMO2_S 2
`define FBR_TMO3_S 10
`define FBR_POWERUP_MS 1000
`define FBR_BLINK_HZ 2
`define FBR_ACT_MS 500
`define FBR_POWERUP_CYC (`FBR_CLK_HZ / 1000 * `FBR_POWERUP_MS)
`define FBR_BLINK_CYC (`FBR_CLK_HZ / (2 * `FBR_BLINK_HZ))
`define FBR_ACT_CYC (`FBR_CLK_HZ / 1000 * `FBR_ACT_MS)
`define FBR_SW1_LOCAL_ONLY 0
`define FBR_SW1_EXT_N 1
`define FBR_SW2_TMO_LO 3
`define FBR_SW2_THR_LO 5
`endif

/* hw/fbr_link_monitor.sv */
`timescale 1ns/1ps
`include "fbr_defines.svh"
module fbr_link_monitor #(
   parameter int CLK_HZ = `FBR_CLK_HZ,
   parameter int SEC_CYC = `FBR_CLK_HZ,
   parameter int POWERUP_CYC = `FBR_POWERUP_CYC,
   parameter int BLINK_CYC = `FBR_BLINK_CYC,
   parameter int ACT_CYC = `FBR_ACT_CYC
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic el_rx,
   input wire logic fo_rx,
   input wire logic fo_signal_detect,
   input wire logic fo_link_up,
   input wire logic remote_link_fail,
   input wire logic hw_error,
   input wire logic [7:0] switch_bank_one,
   input wire logic [7:0] switch_bank_two,
   output logic el_tx,
   output logic el_tx_en,
   output logic fo_tx,
   output logic relay_energise,
   output fbr_pkg::fbr_led_s leds
);
   logic [21:0] meta, sync_q;
   logic el_rx_s, fo_rx_s, sig_det, link_up, remote_fail, hw_err;
   logic [7:0] s1, s2;
   fbr_pkg::fbr_sw_s sw;

   // Pins and switches are asynchronous to sys_clk
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta <= 22'h3FFFFF;
         sync_q <= 22'h3FFFFF;
      end else begin
         meta <= {el_rx, fo_rx, fo_signal_detect, fo_link_up, remote_link_fail, hw_error,
                  switch_bank_one, switch_bank_two};
         sync_q <= meta;
      end
   end

   assign {el_rx_s, fo_rx_s, sig_det, link_up, remote_fail, hw_err, s1, s2} = sync_q;
   assign sw.local_only = s1[`FBR_SW1_LOCAL_ONLY];
   assign sw.ext_n = s1[`FBR_SW1_EXT_N];
   assign sw.thr_sel = s2[`FBR_SW2_THR_LO +: 3];
   assign sw.tmo_sel = s2[`FBR_SW2_TMO_LO +: 2];

   function automatic fbr_pkg::fbr_period_t period_of(input fbr_pkg::fbr_rate_t r);
      int bps;
      case (r)
         4'h0: bps = `FBR_RATE0_BPS;
         4'h1: bps = `FBR_RATE1_BPS;
         4'h2: bps = `FBR_RATE2_BPS;
         4'h3: bps = `FBR_RATE3_BPS;
         4'h4: bps = `FBR_RATE4_BPS;
         4'h5: bps = `FBR_RATE5_BPS;
         4'h6: bps = `FBR_RATE6_BPS;
         4'h7: bps = `FBR_RATE7_BPS;
         4'h8: bps = `FBR_RATE8_BPS;
         default: bps = `FBR_RATE9_BPS;
      endcase
      return 13'((CLK_HZ + bps / 2) / bps);
   endfunction : period_of

   function automatic logic [7:0] thresh_of(input fbr_pkg::fbr_sw_s s);
      if (!s.ext_n) begin
         case (s.thr_sel[1:0])
            2'h0: return `FBR_EXT_THR0;
            2'h1: return `FBR_EXT_THR1;
            2'h2: return `FBR_EXT_THR2;
            default: return `FBR_EXT_THR3;
         endcase
      end
      return {5'h00, s.thr_sel} + 8'h01;
   endfunction : thresh_of

   function automatic logic [31:0] tmo_of(input logic [1:0] sel);
      int secs;
      case (sel)
         2'h0: secs = `FBR_TMO0_S;
         2'h1: secs = `FBR_TMO1_S;
         2'h2: secs = `FBR_TMO2_S;
         default: secs = `FBR_TMO3_S;
      endcase
      return 32'(secs * SEC_CYC);
   endfunction : tmo_of

   fbr_pkg::fbr_rate_t rate, next_rate;
   fbr_pkg::fbr_lock_e lock, next_lock;
   fbr_pkg::fbr_frame_s el_fr, fo_fr;
   fbr_pkg::fbr_period_t period;
   logic [7:0] fault, next_fault, thresh;
   logic [31:0] idle, next_idle, tmo;
   logic el_busy, fo_busy, el2fo_tx, fo2el_tx, good, bad, locked, bad_cfg;

   assign period = period_of(rate);
   assign thresh = thresh_of(sw);
   assign tmo = tmo_of(sw.tmo_sel);
   // Extended mode has only four legal threshold codes
   assign bad_cfg = !sw.ext_n && sw.thr_sel[2];
   assign good = el_fr.good || fo_fr.good;
   assign bad = el_fr.bad || fo_fr.bad;
   assign locked = (lock == fbr_pkg::FBR_LOCKED);

   // Both directions share one detected rate
   fbr_retimer u_el2fo (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .rx_line(el_rx_s),
      .bit_period(period),
      .tx_line(el2fo_tx),
      .busy(el_busy),
      .frame(el_fr)
   );

   fbr_retimer u_fo2el (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .rx_line(fo_rx_s),
      .bit_period(period),
      .tx_line(fo2el_tx),
      .busy(fo_busy),
      .frame(fo_fr)
   );

   always_comb begin
      next_lock = lock;
      next_rate = rate;
      next_fault = fault;
      next_idle = idle;
      unique case (lock)
         fbr_pkg::FBR_HUNT: begin
            next_idle = 32'h0000_0000;
            next_fault = 8'h00;
            if (good) begin
               next_lock = fbr_pkg::FBR_LOCKED;
            end else if (bad) begin
               // Wrong rate garbles the delimiter, so try the next one
               next_rate = (rate == 4'(`FBR_NUM_RATES - 1)) ? `FBR_RATE_RST : rate + 4'h1;
            end
         end
         fbr_pkg::FBR_LOCKED: begin
            if (good) begin
               next_fault = 8'h00;
               next_idle = 32'h0000_0000;
            end else if (bad) begin
               next_idle = 32'h0000_0000;
               if ({1'b0, fault} + 9'h001 >= {1'b0, thresh}) begin
                  next_lock = fbr_pkg::FBR_HUNT;
               end else begin
                  next_fault = fault + 8'h01;
               end
            end else if (idle >= tmo - 32'h0000_0001) begin
               next_lock = fbr_pkg::FBR_HUNT;
            end else begin
               next_idle = idle + 32'h0000_0001;
            end
         end
         default: next_lock = fbr_pkg::FBR_HUNT;
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lock <= fbr_pkg::FBR_HUNT;
         rate <= `FBR_RATE_RST;
         fault <= 8'h00;
         idle <= 32'h0000_0000;
      end else begin
         lock <= next_lock;
         rate <= next_rate;
         fault <= next_fault;
         idle <= next_idle;
      end
   end

   logic [31:0] pcnt, next_pcnt, bcnt, next_bcnt, el_act, next_el_act, fo_act, next_fo_act;
   logic phase, next_phase, pwr_on, err, next_relay;
   fbr_pkg::fbr_led_s next_leds;

   assign pwr_on = (pcnt != 32'(POWERUP_CYC));
   assign err = hw_err || bad_cfg;

   always_comb begin
      next_pcnt = pwr_on ? pcnt + 32'h0000_0001 : pcnt;
      next_phase = phase;
      next_bcnt = bcnt + 32'h0000_0001;
      if (bcnt >= 32'(BLINK_CYC - 1)) begin
         next_bcnt = 32'h0000_0000;
         next_phase = !phase;
      end
      // Stretch covers a whole blink period so a short frame shows
      next_el_act = el_busy ? 32'(ACT_CYC) : (el_act != 32'h0 ? el_act - 32'h1 : el_act);
      next_fo_act = fo_busy ? 32'(ACT_CYC) : (fo_act != 32'h0 ? fo_act - 32'h1 : fo_act);
      next_leds.power_indicator = 1'b1;
      next_leds.rate_lock_indicator = locked;
      next_leds.channel_one_link_indicator = link_up || (sig_det && phase);
      next_leds.channel_two_link_indicator = 1'b0;
      next_leds.electrical_receive_indicator = (el_act != 32'h0) && phase;
      next_leds.optical_receive_indicator = (fo_act != 32'h0) && phase;
      next_leds.local_link_fail_indicator = err ? phase : !link_up;
      next_leds.remote_link_fail_indicator = err ? phase : remote_fail;
      if (pwr_on) next_leds = '1;
      // Relay drops on failure; on power loss it drops by itself
      next_relay = !(!link_up || (!sw.local_only && remote_fail));
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pcnt <= 32'h0000_0000;
         bcnt <= 32'h0000_0000;
         phase <= 1'b0;
         el_act <= 32'h0000_0000;
         fo_act <= 32'h0000_0000;
         leds <= '0;
         relay_energise <= 1'b0;
         el_tx <= 1'b1;
         el_tx_en <= 1'b0;
         fo_tx <= 1'b1;
      end else begin
         pcnt <= next_pcnt;
         bcnt <= next_bcnt;
         phase <= next_phase;
         el_act <= next_el_act;
         fo_act <= next_fo_act;
         leds <= next_leds;
         relay_energise <= next_relay;
         el_tx <= fo2el_tx;
         el_tx_en <= fo_busy;
         fo_tx <= el2fo_tx;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   a_lock_on_good: assert property (!locked && good |=> locked)
      else $error("rate not locked after good frame");
   a_fault_clear: assert property (locked && good |=> fault == 8'h00 && locked)
      else $error("fault count not cleared by good frame");
   a_fault_release: assert property (locked && !good && bad && fault + 8'h01 >= thresh |=> !locked)
      else $error("lock kept after fault threshold");
   a_fault_step: assert property (locked && !good && bad && fault + 8'h01 < thresh
      |=> locked && fault == $past(fault) + 8'h01)
      else $error("fault count did not step");
   a_idle_release: assert property (locked && !good && !bad && idle >= tmo - 32'h1 |=> !locked)
      else $error("lock kept after idle timeout");
   a_hunt_advance: assert property (!locked && bad && !good && rate == 4'h9 |=> rate == 4'h0)
      else $error("rate hunt did not wrap");
   a_lock_led: assert property (!pwr_on |=> leds.rate_lock_indicator == $past(locked))
      else $error("rate lock indicator wrong");
   a_powerup_leds: assert property (pwr_on |=> leds == '1)
      else $error("indicators not all on at power-up");
   a_ch1_steady: assert property (!pwr_on && link_up |=> leds.channel_one_link_indicator)
      else $error("channel one indicator not steady");
   a_fail_blink: assert property (!pwr_on && err |=>
      leds.local_link_fail_indicator == leds.remote_link_fail_indicator)
      else $error("fail indicators not blinking together");
   a_status_local: assert property (sw.local_only && link_up |=> relay_energise)
      else $error("status output tripped by remote failure");
   // Second cycle may legally recover when the link returned one cycle earlier
   a_status_fault: assert property (!link_up |=> !relay_energise ##1 (!relay_energise || $past(link_up)))
      else $error("status output normal during link failure");
   a_status_normal: assert property (link_up && !remote_fail |=> relay_energise)
      else $error("status output tripped while links up");

   // Rate hunt and lock bookkeeping
   a_hunt_step: assert property (!locked && bad && !good && rate != 4'h9 |=> rate == $past(rate) + 4'h1)
      else $error("rate hunt did not step");
   a_locked_rate: assert property (locked |=> rate == $past(rate))
      else $error("rate changed while locked");
   a_hunt_clear: assert property (!locked |=> fault == 8'h00 && idle == 32'h0000_0000)
      else $error("counters not cleared while hunting");
   a_idle_count: assert property (locked && !good && !bad && idle < tmo - 32'h1 |=> locked)
      else $error("lock dropped before idle timeout");

   // Indicators once the power-up phase is over
   a_ch1_dark: assert property (!pwr_on && !link_up && !sig_det |=> !leds.channel_one_link_indicator)
      else $error("channel one indicator lit without light");
   a_el_quiet: assert property (!pwr_on && el_act == 32'h0 |=> !leds.electrical_receive_indicator)
      else $error("electrical receive indicator lit while quiet");
   a_fo_quiet: assert property (!pwr_on && fo_act == 32'h0 |=> !leds.optical_receive_indicator)
      else $error("optical receive indicator lit while quiet");
   a_local_fail: assert property (!pwr_on && !err && !link_up |=> leds.local_link_fail_indicator)
      else $error("local fail indicator dark with link down");
   a_remote_fail: assert property (!pwr_on && !err && remote_fail |=> leds.remote_link_fail_indicator)
      else $error("remote fail indicator dark with far link down");
   a_blink_toggle: assert property (bcnt >= 32'(BLINK_CYC - 1) |=> phase != $past(phase))
      else $error("blink phase did not toggle");
   a_act_stretch: assert property (el_busy |=> el_act == 32'(ACT_CYC))
      else $error("activity stretch not reloaded");
   // Driver enable follows the fibre-to-electrical retimer one cycle later
   a_tx_enable: assert property (fo_busy |=> el_tx_en)
      else $error("electrical driver not enabled while forwarding");

   c_lock: cover property (!locked ##1 locked);
   c_fault_release: cover property (locked && bad ##1 !locked);
   c_idle_release: cover property (locked && !bad && !good ##1 !locked);
   c_ext_mode: cover property (locked && !sw.ext_n && thresh == 8'hFF);
   c_hunt_wrap: cover property (!locked && bad && rate == 4'h9);
endmodule : fbr_link_monitor

/* hw/fbr_pkg.sv */
package fbr_pkg;
   typedef enum logic [1:0] {FBR_HUNT = 2'b00, FBR_LOCKED = 2'b01} fbr_lock_e;
   typedef enum logic {FBR_RT_IDLE = 1'b0, FBR_RT_CHAR = 1'b1} fbr_rt_e;
   typedef logic [3:0] fbr_rate_t;
   typedef logic [12:0] fbr_period_t;
   typedef struct packed {
      logic local_only;
      logic ext_n;
      logic [2:0] thr_sel;
      logic [1:0] tmo_sel;
   } fbr_sw_s;
   typedef struct packed {
      logic good;
      logic bad;
   } fbr_frame_s;
   typedef struct packed {
      logic power_indicator;
      logic rate_lock_indicator;
      logic channel_one_link_indicator;
      logic channel_two_link_indicator;
      logic electrical_receive_indicator;
      logic optical_receive_indicator;
      logic local_link_fail_indicator;
      logic remote_link_fail_indicator;
   } fbr_led_s;
endpackage : fbr_pkg

/* hw/fbr_retimer.sv */
`timescale 1ns/1ps
`include "fbr_defines.svh"
module fbr_retimer (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic rx_line,
   input fbr_pkg::fbr_period_t bit_period,
   output logic tx_line,
   output logic busy,
   output fbr_pkg::fbr_frame_s frame
);
   fbr_pkg::fbr_rt_e state, next_state;
   logic [12:0] cnt, next_cnt;
   logic [3:0] bitn, next_bitn, gap, next_gap;
   logic [10:0] sh, next_sh;
   logic first, next_first, prev, next_tx;
   fbr_pkg::fbr_frame_s next_frame;

   // Start low, stop high, even parity, data one of the delimiters
   function automatic logic delim_ok(input logic [10:0] c);
      logic hit;
      hit = c[8:1] == `FBR_SD1 || c[8:1] == `FBR_SD2 || c[8:1] == `FBR_SD3 || c[8:1] == `FBR_SD4;
      return !c[0] && c[10] && !(^c[9:1]) && hit;
   endfunction : delim_ok

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_bitn = bitn;
      next_gap = gap;
      next_sh = sh;
      next_first = first;
      next_tx = tx_line;
      next_frame = '0;
      unique case (state)
         fbr_pkg::FBR_RT_IDLE: begin
            next_tx = 1'b1;
            if (prev && !rx_line) begin
               next_state = fbr_pkg::FBR_RT_CHAR;
               next_cnt = {1'b0, bit_period[12:1]};
               next_bitn = 4'h0;
            end else if (rx_line) begin
               // A frame head is the first character after a full idle gap
               if (cnt >= bit_period - 13'h0001) begin
                  next_cnt = 13'h0000;
                  if (gap != `FBR_GAP_BITS) next_gap = gap + 4'h1;
                  else next_first = 1'b1;
               end else begin
                  next_cnt = cnt + 13'h0001;
               end
            end else begin
               next_cnt = 13'h0000;
            end
         end
         fbr_pkg::FBR_RT_CHAR: begin
            if (cnt == 13'h0000) begin
               // Bit driven from own mid-bit sample and own period
               next_sh = {rx_line, sh[10:1]};
               next_tx = rx_line;
               next_cnt = bit_period - 13'h0001;
               next_bitn = bitn + 4'h1;
               if (bitn == 4'h0 && rx_line) begin
                  next_state = fbr_pkg::FBR_RT_IDLE;
                  next_tx = 1'b1;
                  next_frame.bad = first;
                  next_first = 1'b0;
                  next_gap = 4'h0;
                  next_cnt = 13'h0000;
               end else if (bitn == `FBR_CHAR_BITS - 4'h1) begin
                  next_state = fbr_pkg::FBR_RT_IDLE;
                  next_frame.good = first && delim_ok(next_sh);
                  next_frame.bad = first && !delim_ok(next_sh);
                  next_first = 1'b0;
                  next_gap = 4'h0;
                  next_cnt = 13'h0000;
               end
            end else begin
               next_cnt = cnt - 13'h0001;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= fbr_pkg::FBR_RT_IDLE;
         cnt <= 13'h0000;
         bitn <= 4'h0;
         gap <= 4'h0;
         sh <= 11'h7FF;
         first <= 1'b1;
         prev <= 1'b1;
         tx_line <= 1'b1;
         frame <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         bitn <= next_bitn;
         gap <= next_gap;
         sh <= next_sh;
         first <= next_first;
         prev <= rx_line;
         tx_line <= next_tx;
         frame <= next_frame;
      end
   end

   assign busy = (state == fbr_pkg::FBR_RT_CHAR);
endmodule : fbr_retimer

/* verification/fbr_station.sv */
`timescale 1ns/1ps
// Bus station on one side of the converter: sends and captures 11-bit chars.
// The line rests high between chars, as the bus idles there.
module fbr_station #(
   parameter int PERIOD = 521
) (
   input wire logic sys_clk,
   input wire logic line_in,
   output logic line_out
);
   initial line_out = 1'b1;

   task send_byte(input logic [7:0] d);
      logic [10:0] f;
      f = {1'b1, ^d, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(negedge sys_clk);
         line_out = f[i];
         repeat (PERIOD - 1) @(negedge sys_clk);
      end
   endtask : send_byte

   // Samples at mid-bit, so edge jitter of the regenerated line is tolerated
   task recv_byte(output logic [10:0] f);
      @(negedge line_in);
      repeat (PERIOD / 2) @(posedge sys_clk);
      for (int i = 0; i < 11; i++) begin
         f[i] = line_in;
         if (i < 10) repeat (PERIOD) @(posedge sys_clk);
      end
   endtask : recv_byte
endmodule : fbr_station

/* verification/tb_fbr_link_monitor.sv */
`timescale 1ns/1ps
module tb_fbr_link_monitor;
   // Slow clock figure keeps the slowest rate short enough to simulate
   localparam int CLK = 5000000;
   localparam int P = (CLK + 4800) / 9600;
   localparam int SEC = 4000;
   localparam int POWER_INDICATOR = 50;
   localparam int LIMIT = 150000;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic sig = 1'b1;
   logic link = 1'b1;
   logic rem = 1'b0;
   logic hw_error = 1'b0;
   logic [7:0] sw1 = 8'h00;
   logic [7:0] sw2 = 8'h00;
   wire el_rx;
   wire fo_rx;
   logic el_tx, el_tx_en, fo_tx, relay;
   fbr_pkg::fbr_led_s leds;
   logic [10:0] got;
   logic [7:0] rows [7] = '{8'hCC, 8'hE5, 8'hFD, 8'h02, 8'h12, 8'h33, 8'h23};
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;
   logic er_seen, or_seen, en_seen;

   initial forever #10 sys_clk = ~sys_clk;

   fbr_link_monitor #(.CLK_HZ(CLK), .SEC_CYC(SEC), .POWERUP_CYC(POWER_INDICATOR), .BLINK_CYC(8), .ACT_CYC(32)) dut (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .el_rx(el_rx), .fo_rx(fo_rx), .fo_signal_detect(sig),
      .fo_link_up(link), .remote_link_fail(rem), .hw_error(hw_error), .switch_bank_one(sw1),
      .switch_bank_two(sw2), .el_tx(el_tx), .el_tx_en(el_tx_en), .fo_tx(fo_tx),
      .relay_energise(relay), .leds(leds));
   fbr_station #(.PERIOD(P)) el_side (.sys_clk(sys_clk), .line_in(el_tx), .line_out(el_rx));
   fbr_station #(.PERIOD(P)) fo_side (.sys_clk(sys_clk), .line_in(fo_tx), .line_out(fo_rx));

   always @(negedge sys_clk) begin
      if (leds.electrical_receive_indicator === 1'b1) er_seen = 1'b1;
      if (leds.optical_receive_indicator === 1'b1) or_seen = 1'b1;
      if (el_tx_en === 1'b1) en_seen = 1'b1;
   end

   task finish_test();
      if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         n_mismatch++;
         finish_test();
      end
   end

   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task do_reset();
      @(negedge sys_clk);
      sys_rst = 1'b1;
      repeat (8) @(negedge sys_clk);
      check("reset outputs", {leds, relay, el_tx, fo_tx, el_tx_en}, 16'h0006);
      sys_rst = 1'b0;
      repeat (10) @(negedge sys_clk);
      check("power-up leds", leds, 16'h00FF);
      repeat (POWER_INDICATOR) @(negedge sys_clk);
   endtask : do_reset

   // Counts highs of {ch1, local fail, remote fail}; a blinking one is neither stuck high nor low
   task blink(input logic [2:0] mask);
      int c [3];
      c = '{0, 0, 0};
      repeat (32) begin
         @(negedge sys_clk);
         if (leds.channel_one_link_indicator) c[2]++;
         if (leds.local_link_fail_indicator) c[1]++;
         if (leds.remote_link_fail_indicator) c[0]++;
      end
      for (int b = 0; b < 3; b++) if (mask[b]) check("blink", 16'(c[b] > 0 && c[b] < 32), 16'h0001);
   endtask : blink

   task el_frame(input logic [7:0] d);
      fork
         el_side.send_byte(d);
         fo_side.recv_byte(got);
      join
      check("fibre char", got, {5'h00, 1'b1, ^d, d, 1'b0});
      repeat (5) @(negedge sys_clk);
   endtask : el_frame

   task fo_frame(input logic [7:0] d);
      fork
         fo_side.send_byte(d);
         el_side.recv_byte(got);
      join
      check("electrical char", got, {5'h00, 1'b1, ^d, d, 1'b0});
      repeat (5) @(negedge sys_clk);
   endtask : fo_frame

   task gap();
      repeat (12 * P) @(negedge sys_clk);
   endtask : gap

   initial begin
      do_reset();
      check("power led", {leds.power_indicator, leds.channel_two_link_indicator}, 16'h0002);
      foreach (rows[i]) begin
         {link, sig, rem, sw1[0]} = rows[i][7:4];
         repeat (6) @(negedge sys_clk);
         check("status row", {relay, leds.channel_one_link_indicator, leds.local_link_fail_indicator,
            leds.remote_link_fail_indicator}, {12'h000, rows[i][3:0]});
      end
      {link, sig, rem, sw1} = {3'b010, 8'h00};
      blink(3'b100);
      {link, hw_error} = 2'b11;
      blink(3'b011);
      {hw_error, sw2} = {1'b0, 8'h80};
      blink(3'b011);
      sw2 = 8'h08;
      er_seen = 1'b0;
      el_frame(8'h68);
      check("lock after good head", leds.rate_lock_indicator, 16'h0001);
      check("electrical activity", er_seen, 16'h0001);
      repeat (2900) @(negedge sys_clk);
      check("lock before timeout", leds.rate_lock_indicator, 16'h0001);
      check("electrical quiet", leds.electrical_receive_indicator, 16'h0000);
      repeat (1300) @(negedge sys_clk);
      check("lock after timeout", leds.rate_lock_indicator, 16'h0000);
      {sw1, sw2} = {8'h02, 8'h20};
      do_reset();
      el_frame(8'h68);
      check("lock", leds.rate_lock_indicator, 16'h0001);
      gap();
      el_frame(8'h55);
      check("one faulty of two", leds.rate_lock_indicator, 16'h0001);
      gap();
      {or_seen, en_seen} = 2'b00;
      fo_frame(8'h10);
      check("fibre head kept lock", leds.rate_lock_indicator, 16'h0001);
      check("optical activity", {or_seen, en_seen}, 16'h0003);
      gap();
      check("optical quiet", leds.optical_receive_indicator, 16'h0000);
      el_frame(8'h33);
      check("count cleared by good", leds.rate_lock_indicator, 16'h0001);
      gap();
      el_frame(8'h33);
      check("released at threshold", leds.rate_lock_indicator, 16'h0000);
      finish_test();
   end
endmodule : tb_fbr_link_monitor
